// >>> mqps_pkg.sv
/*
  shared constants for the multi-queue port select block: queue and
  address geometry, strap sync positions, default depths and offsets,
  and the one-hot state encodings.
  assumes a single clock domain, the master clock at 25 MHz.
*/
package mqps_pkg;
  localparam int NQ = 32;
  localparam int QB = 5;
  localparam int IDB = 3;
  localparam int AB = 8;
  localparam int DW = 18;
  localparam int BUSW = 8;
  localparam int CLK_NS = 40;
  // default per-queue depths, small and large variant
  localparam int D9_SMALL = 4096;
  localparam int D18_SMALL = 2048;
  localparam int D9_LARGE = 8192;
  localparam int D18_LARGE = 4096;
  // almost flag offsets picked by the offset strap
  localparam int OFS_LOW = 8;
  localparam int OFS_HIGH = 128;
  // strap synchroniser bit positions
  localparam int SY_MRS = 0;
  localparam int SY_DFM = 1;
  localparam int SY_DOF = 2;
  localparam int SY_IX9 = 3;
  localparam int SY_OX9 = 4;
  localparam int SY_CHN = 5;
  localparam int SY_ID = 6;
  localparam int SYW = 9;
  // id field of the address buses
  localparam int ID_LSB = 5;
  typedef enum logic [1:0] {
    WS_IDLE = 2'h1,
    WS_HAND = 2'h2
  } mqps_wst_t;
  typedef enum logic [3:0] {
    RS_RUN = 4'h1,
    RS_OLD = 4'h2,
    RS_GAP = 4'h4,
    RS_LOAD = 4'h8
  } mqps_rst_t;
endpackage

// >>> mqps_buf.sv
/*
  two-entry word buffer with valid and ready on both sides.
  assumes its drain side may stall at any time; no word is ever lost.
*/
`timescale 1ns/100ps
module mqps_buf #(
  parameter int W = 23,
  parameter int DEPTH = 2
) (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [W-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [W-1:0] o_out_data
);
  localparam int PB = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] ent;
    logic [PB-1:0] wp;
    logic [PB-1:0] rp;
    logic [PB:0] cnt;
  } mqps_buf_st_t;

  mqps_buf_st_t s_q;
  mqps_buf_st_t s_d;
  logic push;
  logic pop;

  initial
  begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
      $error("buffer depth must be a power of two, at least 2");
  end

  assign o_in_ready = (s_q.cnt != (PB+1)'(DEPTH));
  assign o_out_valid = (s_q.cnt != '0);
  assign o_out_data = s_q.ent[s_q.rp];
  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;

  always_comb
  begin
    s_d = s_q;
    if (push)
    begin
      s_d.ent[s_q.wp] = i_in_data;
      s_d.wp = s_q.wp + PB'(1);
    end
    if (pop)
      s_d.rp = s_q.rp + PB'(1);
    s_d.cnt = s_q.cnt + (PB+1)'(push) - (PB+1)'(pop);
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_rstn)
      s_q <= '0;
    else if (i_ce)
      s_q <= s_d;
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn || !i_ce);

  hold_when_stalled_a: assert property (
    (o_out_valid && !i_out_ready && !push) |=>
      (o_out_valid && o_out_data == $past(o_out_data)))
    else $error("stalled buffer head changed");
endmodule // mqps_buf

// >>> mqps_cfg.sv
/*
  default-mode setup loader: walks the per-queue setup slots after a
  master reset and reports completion on the active-low done output,
  which follows the chain input once loading has finished.
  assumes straps and chain input are already synchronised.
*/
`timescale 1ns/100ps
module mqps_cfg #(
  parameter int NQ = mqps_pkg::NQ
) (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic i_mrs_n,
  input wire logic i_dfm,
  input wire logic i_chain_n,
  output logic o_cfg_ok,
  output logic o_cfg_done_out_n
);
  localparam int CB = $clog2(NQ + 1);

  typedef struct packed {
    logic [CB-1:0] slot;
    logic loaded;
    logic done;
  } mqps_cfg_st_t;

  mqps_cfg_st_t s_q;
  mqps_cfg_st_t s_d;

  initial
  begin
    if (NQ < 1)
      $error("queue count must be at least 1");
  end

  always_comb
  begin
    s_d = s_q;
    if (!i_mrs_n)
    begin
      s_d = '0;
    end
    else if (i_dfm && !s_q.loaded)
    begin
      // one setup slot per queue, loaded on successive clocks
      s_d.slot = s_q.slot + CB'(1);                           // RULE2 RULE5
      s_d.loaded = (s_q.slot == CB'(NQ - 1));
    end
    s_d.done = s_q.loaded & !i_chain_n;                       // RULE7
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_rstn)
      s_q <= '0;
    else if (i_ce)
      s_q <= s_d;
  end

  assign o_cfg_ok = s_q.loaded;
  assign o_cfg_done_out_n = ~s_q.done;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn || !i_ce);

  serial_mode_idle_a: assert property ( // RULE1
    (!i_dfm && !s_q.loaded) |=> !s_q.loaded)
    else $error("setup loaded without default mode");
  done_follows_chain_a: assert property ( // RULE7
    (s_q.loaded && i_mrs_n) |=> (o_cfg_done_out_n == $past(i_chain_n)))
    else $error("done output does not follow chain input");
endmodule // mqps_cfg

// >>> mqps_top.sv
/*
  multi-queue port select: 32 queues behind one write port and one read
  port, queue switching with its handover latencies, device id match,
  flag bus quadrant strobes, and default setup at master reset.
  assumes host ports are logic on i_mclk; straps and master reset are
  pins and are synchronised here. write and read clocks are i_mclk.
  // Overview of operation
  // RULE1: default-mode strap high at master reset means default setup, no serial.
  // RULE2: default setup builds all 32 queues sharing memory equally.
  // RULE3: depth 4096 x9 or 2048 x18; large variant 8192 x9 or 4096 x18.
  // RULE4: almost offsets are 8 with offset strap low, 128 with it high.
  // RULE5: host keeps clocking after reset until done output falls.
  // RULE6: host holds chain input enable low during default setup.
  // RULE7: done output follows chain input once loaded, feeding next device.
  // RULE8: write queue taken from address when write select enable high.
  // RULE9: a selected queue stays selected until another is chosen.
  // RULE10: host spaces write queue selections at least 3 clocks apart.
  // RULE11: full flag shows new queue on the edge after selection.
  // RULE12: new queue written from second edge on; full queue refuses writes.
  // RULE13: selection edge and next edge still write the previous queue.
  // RULE14: low 5 address bits pick the queue, top 3 must match id.
  // RULE15: full strobe without select enable latches quadrant from bits 1:0.
  // RULE16: read queue taken from address when read select enable high.
  // RULE17: host spaces read queue selections at least 3 clocks apart.
  // RULE18: new read queue word reaches output register 3 clocks later.
  // RULE19: selection edge reads old queue if enabled; next edge reads always.
  // RULE20: output enable only floats the data; output register still loads.
  // RULE21: empty new queue: no read, last word stays, valid goes inactive.
  // RULE22: empty strobe with read address picks quadrant for empty bus.
  // RULE23: quadrant 00..11 maps queues 0-7 .. 24-31 onto bus lines 0-7.
  // RULE24: master reset low samples mode, offset, width and id straps.
*/
`timescale 1ns/100ps
module mqps_top #(
  parameter bit LARGE = 1'b0
) (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic i_master_reset_n,
  input wire logic i_default_cfg_select,
  input wire logic i_default_offset_select,
  input wire logic i_in_x9,
  input wire logic i_out_x9,
  input wire logic [2:0] i_chip_select_id,
  input wire logic i_cfg_chain_in_enable_n,
  output logic o_cfg_done_out_n,
  input wire logic i_wr_queue_sel_en,
  input wire logic [7:0] i_wr_queue_addr,
  input wire logic i_almost_full_bus_strobe,
  input wire logic i_wr_en_n,
  input wire logic [17:0] i_wr_data,
  output logic o_wr_ready,
  output logic o_active_full_n,
  output logic o_almost_full_n,
  output logic [7:0] o_almost_full_bus,
  input wire logic i_rd_queue_sel_en,
  input wire logic [7:0] i_rd_queue_addr,
  input wire logic i_almost_empty_bus_strobe,
  input wire logic i_rd_en_n,
  input wire logic i_out_en_n,
  output logic [17:0] o_rd_data,
  output logic o_rd_data_oe_n,
  output logic o_out_valid_n,
  output logic o_almost_empty_n,
  output logic [7:0] o_almost_empty_bus
);
  localparam int NQ = mqps_pkg::NQ;
  localparam int QB = mqps_pkg::QB;
  localparam int DW = mqps_pkg::DW;
  localparam int D9 = LARGE ? mqps_pkg::D9_LARGE : mqps_pkg::D9_SMALL;
  localparam int D18 = LARGE ? mqps_pkg::D18_LARGE : mqps_pkg::D18_SMALL;
  localparam int PW = $clog2(D9);
  localparam int BW = QB + DW;

  typedef struct packed {
    logic [mqps_pkg::SYW-1:0] sy1;
    logic [mqps_pkg::SYW-1:0] sy2;
    logic default_cfg_select;
    logic dof;
    logic x9b;
    logic [2:0] id;
    logic [QB-1:0] wcur;
    logic [QB-1:0] wnew;
    mqps_pkg::mqps_wst_t wst;
    logic [QB-1:0] rcur;
    logic [QB-1:0] rnew;
    mqps_pkg::mqps_rst_t rst;
    logic [NQ-1:0][PW-1:0] wp;
    logic [NQ-1:0][PW-1:0] rp;
    logic [NQ-1:0][PW:0] cnt;
    logic [DW-1:0] rdata;
    logic ov;
    logic full;
    logic almost_full_n;
    logic almost_empty_n;
    logic [1:0] fquad;
    logic [1:0] equad;
    logic [7:0] afb;
    logic [7:0] aeb;
  } mqps_top_st_t;

  mqps_top_st_t s_q;
  mqps_top_st_t s_d;
  logic [DW-1:0] mem [NQ*D9];
  logic cfg_ok;
  logic mrs_n;
  logic [PW:0] cap;
  logic [PW:0] ofs;
  logic [NQ-1:0] qfull;
  logic [NQ-1:0] qaf;
  logic [NQ-1:0] qae;
  logic wsel;
  logic rsel;
  logic push;
  logic buf_valid;
  logic drain;
  logic [BW-1:0] buf_out;
  logic [QB-1:0] drain_q;
  logic pop;
  logic [DW-1:0] head;

  initial
  begin
    if (D9 != 2 * D18)
      $error("x9 depth must be twice the x18 depth");
  end

  function automatic logic id_hit(logic [7:0] a, logic [2:0] id);
    return a[7:mqps_pkg::ID_LSB] == id;                       // RULE14
  endfunction

  function automatic logic [7:0] quad(logic [NQ-1:0] v, logic [1:0] q);
    return v[q*8 +: 8];                                       // RULE23
  endfunction

  function automatic logic [PW-1:0] nxt(logic [PW-1:0] p, logic [PW:0] c);
    return ((PW+1)'(p) + (PW+1)'(1) == c) ? '0 : p + PW'(1);
  endfunction

  assign mrs_n = s_q.sy2[mqps_pkg::SY_MRS];
  assign cap = s_q.x9b ? (PW+1)'(D9) : (PW+1)'(D18);         // RULE3
  assign ofs = s_q.dof ? (PW+1)'(mqps_pkg::OFS_HIGH)
                       : (PW+1)'(mqps_pkg::OFS_LOW);          // RULE4

  for (genvar g = 0; g < NQ; g++)
  begin : g_flag
    assign qfull[g] = (s_q.cnt[g] == cap);
    assign qaf[g] = (s_q.cnt[g] >= cap - ofs);
    assign qae[g] = (s_q.cnt[g] <= ofs);
  end

  mqps_cfg #(.NQ(NQ)) u_cfg (
    .i_mclk(i_mclk),
    .i_rstn(i_rstn),
    .i_ce(i_ce),
    .i_mrs_n(mrs_n),
    .i_dfm(s_q.default_cfg_select),
    .i_chain_n(s_q.sy2[mqps_pkg::SY_CHN]),
    .o_cfg_ok(cfg_ok),
    .o_cfg_done_out_n(o_cfg_done_out_n)
  );

  assign wsel = mrs_n & cfg_ok & i_wr_queue_sel_en
              & id_hit(i_wr_queue_addr, s_q.id);              // RULE8
  assign rsel = mrs_n & cfg_ok & i_rd_queue_sel_en
              & id_hit(i_rd_queue_addr, s_q.id)
              & (s_q.rst == mqps_pkg::RS_RUN);                // RULE16
  // words carry the queue that was current on their edge
  assign push = mrs_n & cfg_ok & !i_wr_en_n;                  // RULE13
  assign drain_q = buf_out[BW-1:DW];
  assign drain = buf_valid & mrs_n & !qfull[drain_q];         // RULE12
  assign head = mem[{s_q.rcur, s_q.rp[s_q.rcur]}];

  // master reset drops words still buffered for the old setup
  mqps_buf #(.W(BW), .DEPTH(2)) u_buf (
    .i_mclk(i_mclk),
    .i_rstn(i_rstn & mrs_n),
    .i_ce(i_ce),
    .i_in_valid(push),
    .o_in_ready(o_wr_ready),
    .i_in_data({s_q.wcur, i_wr_data}),
    .o_out_valid(buf_valid),
    .i_out_ready(drain),
    .o_out_data(buf_out)
  );

  always_comb
  begin
    s_d = s_q;
    pop = 1'b0;
    s_d.sy1 = {i_chip_select_id, i_cfg_chain_in_enable_n, i_out_x9,
               i_in_x9, i_default_offset_select, i_default_cfg_select,
               i_master_reset_n};
    s_d.sy2 = s_q.sy1;
    if (!mrs_n)
    begin
      // straps sampled on every clock during master reset
      s_d.default_cfg_select = s_q.sy2[mqps_pkg::SY_DFM];                    // RULE24 RULE1
      s_d.dof = s_q.sy2[mqps_pkg::SY_DOF];                    // RULE24 RULE4
      s_d.x9b = s_q.sy2[mqps_pkg::SY_IX9]
              & s_q.sy2[mqps_pkg::SY_OX9];                    // RULE24 RULE3
      s_d.id = s_q.sy2[mqps_pkg::SY_ID +: 3];                 // RULE24
      s_d.wcur = '0;
      s_d.rcur = '0;
      s_d.wst = mqps_pkg::WS_IDLE;
      s_d.rst = mqps_pkg::RS_RUN;
      s_d.wp = '0;
      s_d.rp = '0;
      s_d.cnt = '0;
      s_d.ov = 1'b0;
      s_d.full = 1'b0;
    end
    else
    begin
      case (s_q.wst)
        mqps_pkg::WS_IDLE:
        begin
          if (wsel)
          begin
            s_d.wnew = i_wr_queue_addr[QB-1:0];               // RULE9
            s_d.wst = mqps_pkg::WS_HAND;
          end
          s_d.full = qfull[s_q.wcur];
        end
        mqps_pkg::WS_HAND:
        begin
          s_d.wcur = s_q.wnew;                                // RULE12
          s_d.wst = mqps_pkg::WS_IDLE;
          s_d.full = qfull[s_q.wnew];                         // RULE11
        end
        default: s_d.wst = mqps_pkg::WS_IDLE;
      endcase
      if (!i_wr_queue_sel_en && i_almost_full_bus_strobe
          && id_hit(i_wr_queue_addr, s_q.id))
        s_d.fquad = i_wr_queue_addr[1:0];                     // RULE15
      if (!i_rd_queue_sel_en && i_almost_empty_bus_strobe
          && id_hit(i_rd_queue_addr, s_q.id))
        s_d.equad = i_rd_queue_addr[1:0];                     // RULE22
      case (s_q.rst)
        mqps_pkg::RS_RUN:
        begin
          if (rsel)
          begin
            s_d.rnew = i_rd_queue_addr[QB-1:0];               // RULE9
            s_d.rst = mqps_pkg::RS_OLD;
          end
          pop = (s_q.cnt[s_q.rcur] != '0) & (!i_rd_en_n | !s_q.ov); // RULE19
          if (!pop && !i_rd_en_n)
            s_d.ov = 1'b0;
        end
        mqps_pkg::RS_OLD:
        begin
          pop = (s_q.cnt[s_q.rcur] != '0);                    // RULE19
          if (!pop && !i_rd_en_n)
            s_d.ov = 1'b0;
          s_d.rcur = s_q.rnew;
          s_d.rst = mqps_pkg::RS_GAP;
        end
        mqps_pkg::RS_GAP:
        begin
          if (!i_rd_en_n)
            s_d.ov = 1'b0;
          s_d.rst = mqps_pkg::RS_LOAD;
        end
        mqps_pkg::RS_LOAD:
        begin
          pop = (s_q.cnt[s_q.rcur] != '0);                    // RULE18
          if (!pop)
            s_d.ov = 1'b0;                                    // RULE21
          s_d.rst = mqps_pkg::RS_RUN;
        end
        default: s_d.rst = mqps_pkg::RS_RUN;
      endcase
      // output register loads whatever the output enable
      if (pop)
      begin
        s_d.rdata = head;                                     // RULE20
        s_d.ov = 1'b1;
        s_d.rp[s_q.rcur] = nxt(s_q.rp[s_q.rcur], cap);
      end
      if (drain)
        s_d.wp[drain_q] = nxt(s_q.wp[drain_q], cap);
      for (int q = 0; q < NQ; q++)
        s_d.cnt[q] = s_q.cnt[q]
                   + (PW+1)'(drain && drain_q == QB'(q))
                   - (PW+1)'(pop && s_q.rcur == QB'(q));
    end
    s_d.almost_full_n = qaf[s_q.wcur];
    s_d.almost_empty_n = qae[s_q.rcur];
    s_d.afb = quad(qaf, s_q.fquad);                           // RULE15
    s_d.aeb = quad(qae, s_q.equad);                           // RULE22 RULE23
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_rstn)
    begin
      s_q <= '0;
      s_q.wst <= mqps_pkg::WS_IDLE;
      s_q.rst <= mqps_pkg::RS_RUN;
    end
    else if (i_ce)
      s_q <= s_d;
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_ce && drain)
      mem[{drain_q, s_q.wp[drain_q]}] <= buf_out[DW-1:0];
  end

  assign o_active_full_n = ~s_q.full;
  assign o_almost_full_n = ~s_q.almost_full_n;
  assign o_almost_empty_n = ~s_q.almost_empty_n;
  assign o_almost_full_bus = ~s_q.afb;
  assign o_almost_empty_bus = ~s_q.aeb;
  assign o_rd_data = s_q.rdata;
  assign o_rd_data_oe_n = i_out_en_n;                         // RULE20
  assign o_out_valid_n = ~s_q.ov;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn || !i_ce);

  sequence rd_steps_s;
    s_q.rst == mqps_pkg::RS_OLD ##1 s_q.rst == mqps_pkg::RS_GAP
      ##1 s_q.rst == mqps_pkg::RS_LOAD;
  endsequence

  wr_queue_pick_a: assert property ( // RULE8
    (wsel && s_q.wst == mqps_pkg::WS_IDLE) |->
      ##2 (s_q.wcur == $past(i_wr_queue_addr[QB-1:0], 2)))
    else $error("write queue not taken two edges after select");
  wr_old_hold_a: assert property ( // RULE13
    (wsel && s_q.wst == mqps_pkg::WS_IDLE) |=>
      (s_q.wcur == $past(s_q.wcur)) ##1 (s_q.wst == mqps_pkg::WS_IDLE))
    else $error("previous write queue dropped too early");
  full_switch_a: assert property ( // RULE11
    (s_q.wst == mqps_pkg::WS_HAND && mrs_n) |=>
      (o_active_full_n == !$past(qfull[s_q.wnew])))
    else $error("full flag did not follow new queue");
  id_miss_a: assert property ( // RULE14
    (i_wr_queue_sel_en && !id_hit(i_wr_queue_addr, s_q.id)
      && s_q.wst == mqps_pkg::WS_IDLE) |=> s_q.wst == mqps_pkg::WS_IDLE)
    else $error("write select taken with wrong id");
  rd_switch_a: assert property ( // RULE16
    rsel |=> rd_steps_s)
    else $error("read switch sequence broken");
  rd_fall_a: assert property ( // RULE18
    (s_q.rst == mqps_pkg::RS_LOAD && s_q.cnt[s_q.rcur] != '0 && mrs_n)
      |=> (!o_out_valid_n && o_rd_data == $past(head)))
    else $error("new queue word did not reach output");
  rd_empty_a: assert property ( // RULE21
    (s_q.rst == mqps_pkg::RS_LOAD && s_q.cnt[s_q.rcur] == '0 && mrs_n)
      |=> (o_out_valid_n && $stable(o_rd_data)))
    else $error("empty queue select mishandled");
  full_quad_a: assert property ( // RULE15
    (mrs_n && !i_wr_queue_sel_en && i_almost_full_bus_strobe
      && id_hit(i_wr_queue_addr, s_q.id)) |=>
      (s_q.fquad == $past(i_wr_queue_addr[1:0]))
      ##1 (o_almost_full_bus == ~$past(quad(qaf, s_q.fquad))))
    else $error("almost full quadrant not applied");
endmodule // mqps_top

// >>> mqps_host.sv
/*
  host write-port model: selects a write queue, then streams words into it,
  holding each word until the block's ready is seen high at a rising edge.
  assumes the bench holds its queue, count and base steady while busy.
*/
`timescale 1ns/100ps
module mqps_host (
  input wire logic i_mclk,
  input wire logic i_go,
  input wire logic [2:0] i_id,
  input wire logic [4:0] i_q,
  input wire logic [11:0] i_n,
  input wire logic [17:0] i_base,
  input wire logic i_wr_ready,
  output logic o_sel_en,
  output logic [7:0] o_addr,
  output logic o_wr_en_n,
  output logic [17:0] o_wr_data,
  output logic o_busy
);
  logic [11:0] cnt;
  initial
  begin
    o_sel_en = 1'b0;
    o_addr = 8'h00;
    o_wr_en_n = 1'b1;
    o_wr_data = 18'h00000;
    o_busy = 1'b0;
    forever
    begin
      @(posedge i_mclk);
      if (i_go === 1'b1)
      begin
        o_busy = 1'b1;
        @(negedge i_mclk);
        o_sel_en = 1'b1;
        o_addr = {i_id, i_q};
        @(negedge i_mclk);
        o_sel_en = 1'b0;
        // released bus shows no stale value
        o_addr = ~o_addr;
        // first edge after selection still feeds the old queue
        @(negedge i_mclk);
        cnt = 12'h000;
        while (cnt < i_n)
        begin
          o_wr_en_n = 1'b0;
          o_wr_data = i_base + {6'h00, cnt};
          @(posedge i_mclk);
          if (i_wr_ready === 1'b1)
            cnt = cnt + 12'h001;
          @(negedge i_mclk);
        end
        o_wr_en_n = 1'b1;
        o_wr_data = ~o_wr_data;
        // spacing before any further selection
        repeat (2) @(negedge i_mclk);
        o_busy = 1'b0;
      end
    end
  end
endmodule // mqps_host

// >>> test_multi_queue_port_select.sv
/*
  self-checking bench for the port select block with a host write model.
  assumes x18 ports, default setup, a single device; offset strap low, then high for the second setup.
*/
`timescale 1ns/100ps
module test_multi_queue_port_select;
  localparam logic [2:0] ID = 3'h5;
  logic clk, rstn, mrs_n, default_cfg_select, chain_n, go, h_sel, h_wen_n, h_busy;
  logic almost_full_bus_strobe, almost_empty_bus_strobe, rsel, ren_n, oen_n, wr_ready, full_n, afull_n;
  logic done_n, oe_n, valid_n, aempty_n, dof;
  logic [4:0] q;
  logic [11:0] n;
  logic [17:0] base, h_data, rd_data;
  logic [7:0] h_addr, qaddr, raddr, fbus, ebus;
  int mismatches, compares;
  mqps_host i_host (.i_mclk(clk), .i_go(go), .i_id(ID), .i_q(q), .i_n(n),
    .i_base(base), .i_wr_ready(wr_ready), .o_sel_en(h_sel), .o_addr(h_addr),
    .o_wr_en_n(h_wen_n), .o_wr_data(h_data), .o_busy(h_busy));
  mqps_top i_dut (.i_mclk(clk), .i_rstn(rstn), .i_ce(1'b1),
    .i_master_reset_n(mrs_n), .i_default_cfg_select(default_cfg_select),
    .i_default_offset_select(dof), .i_in_x9(1'b0), .i_out_x9(1'b0),
    .i_chip_select_id(ID), .i_cfg_chain_in_enable_n(chain_n),
    .o_cfg_done_out_n(done_n), .i_wr_queue_sel_en(h_sel),
    .i_wr_queue_addr(almost_full_bus_strobe ? qaddr : h_addr), .i_almost_full_bus_strobe(almost_full_bus_strobe),
    .i_wr_en_n(h_wen_n), .i_wr_data(h_data), .o_wr_ready(wr_ready),
    .o_active_full_n(full_n), .o_almost_full_n(afull_n),
    .o_almost_full_bus(fbus), .i_rd_queue_sel_en(rsel),
    .i_rd_queue_addr(raddr), .i_almost_empty_bus_strobe(almost_empty_bus_strobe),
    .i_rd_en_n(ren_n), .i_out_en_n(oen_n), .o_rd_data(rd_data),
    .o_rd_data_oe_n(oe_n), .o_out_valid_n(valid_n),
    .o_almost_empty_n(aempty_n), .o_almost_empty_bus(ebus));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [17:0] seen, exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic wait_for(input bit on_full, input logic lvl, input int lim);
    int i;
    for (i = 0; i < lim && (on_full ? full_n : done_n) !== lvl; i++)
      @(negedge clk);
  endtask
  task automatic cfg_reset();
    mrs_n = 1'b0;
    repeat (6) @(negedge clk);
    mrs_n = 1'b1;
    chk("done before load", {17'h0, done_n}, 18'h00001);
    chk("ready in reset", {17'h0, wr_ready}, 18'h00001);
    chk("valid in reset", {17'h0, valid_n}, 18'h00001);
    wait_for(1'b0, 1'b0, 200);
    chk("done", {17'h0, done_n}, 18'h00000);
  endtask
  task automatic host_write(input logic [4:0] wq, input logic [11:0] wn,
    input logic [17:0] wb);
    int i;
    @(negedge clk);
    q = wq;
    n = wn;
    base = wb;
    go = 1'b1;
    @(negedge clk);
    go = 1'b0;
    for (i = 0; i < 6000 && h_busy !== 1'b0; i++)
      @(negedge clk);
  endtask
  task automatic rd_sel(input logic [2:0] id, input logic [4:0] rq,
    input logic pop);
    @(negedge clk);
    rsel = 1'b1;
    raddr = {id, rq};
    ren_n = ~pop;
    @(negedge clk);
    rsel = 1'b0;
    raddr = ~raddr;
    ren_n = 1'b1;
    repeat (3) @(negedge clk);
  endtask
  task automatic rd_one();
    @(negedge clk);
    ren_n = 1'b0;
    @(negedge clk);
    ren_n = 1'b1;
    repeat (2) @(negedge clk);
  endtask
  task automatic quad(input logic wr, input logic [1:0] code,
    input logic [7:0] exp);
    @(negedge clk);
    almost_full_bus_strobe = wr;
    almost_empty_bus_strobe = ~wr;
    qaddr = {ID, 3'h0, code};
    raddr = {ID, 3'h0, code};
    @(negedge clk);
    almost_full_bus_strobe = 1'b0;
    almost_empty_bus_strobe = 1'b0;
    @(negedge clk);
    chk(wr ? "full bus" : "empty bus", {10'h000, wr ? fbus : ebus},
      {10'h000, exp});
  endtask
  initial
  begin
    #(40 * 20000);
    mismatches++;
    conclude();
  end
  initial
  begin
    int c;
    mismatches = 0;
    compares = 0;
    rstn = 1'b0;
    mrs_n = 1'b1;
    default_cfg_select = 1'b1;
    chain_n = 1'b0;
    go = 1'b0;
    q = 5'h00;
    n = 12'h000;
    base = 18'h00000;
    almost_full_bus_strobe = 1'b0;
    almost_empty_bus_strobe = 1'b0;
    rsel = 1'b0;
    ren_n = 1'b1;
    oen_n = 1'b0;
    dof = 1'b0;
    qaddr = 8'h00;
    raddr = 8'h00;
    repeat (5) @(negedge clk);
    rstn = 1'b1;
    repeat (3) @(negedge clk);
    cfg_reset();
    host_write(5'h03, 12'h004, 18'h00100);
    // fill a whole default queue of 2048 words, ready stays high throughout
    host_write(5'h09, 12'h800, 18'h01000);
    wait_for(1'b1, 1'b0, 20);
    chk("full", {17'h0, full_n}, 18'h00000);
    chk("almost full", {17'h0, afull_n}, 18'h00000);
    for (c = 0; c < 4; c++)
      quad(1'b1, c[1:0], (c == 1) ? 8'hfd : 8'hff);
    for (c = 0; c < 4; c++)
      quad(1'b0, c[1:0], (c == 1) ? 8'h02 : 8'h00);
    host_write(5'h0a, 12'h000, 18'h00000);
    chk("full after switch", {17'h0, full_n}, 18'h00001);
    rd_sel(ID, 5'h03, 1'b0);
    chk("valid q3", {17'h0, valid_n}, 18'h00000);
    chk("head q3", rd_data, 18'h00100);
    rd_sel(~ID, 5'h07, 1'b0);
    chk("foreign id", {17'h0, valid_n}, 18'h00000);
    chk("foreign id data", rd_data, 18'h00100);
    oen_n = 1'b1;
    rd_one();
    chk("float", {17'h0, oe_n}, 18'h00001);
    chk("loaded floating", rd_data, 18'h00101);
    oen_n = 1'b0;
    @(negedge clk);
    chk("drive", {17'h0, oe_n}, 18'h00000);
    rd_sel(ID, 5'h07, 1'b1);
    chk("empty q valid", {17'h0, valid_n}, 18'h00001);
    chk("last old word", rd_data, 18'h00103);
    // two words for the full queue stall the buffer
    host_write(5'h09, 12'h002, 18'h02000);
    chk("stalled ready", {17'h0, wr_ready}, 18'h00000);
    chk("full q9 again", {17'h0, full_n}, 18'h00000);
    dof = 1'b1;
    cfg_reset();
    host_write(5'h01, 12'h00a, 18'h00300);
    rd_sel(ID, 5'h01, 1'b0);
    chk("head q1", rd_data, 18'h00300);
    chk("almost empty 128", {17'h0, aempty_n}, 18'h00000);
    chain_n = 1'b1;
    repeat (5) @(negedge clk);
    chk("done follows chain", {17'h0, done_n}, 18'h00001);
    conclude();
  end
endmodule // test_multi_queue_port_select
